// ==== rtl/sbsc_defs.svh ====
// constants of the burst sram control block
// assumes single 100 MHz clock domain
`ifndef SBSC_DEFS_SVH
`define SBSC_DEFS_SVH
`define SBSC_LANES 4
`define SBSC_LANE_W 9
`define SBSC_DATA_W 36
`define SBSC_ADDR_W 10
`define SBSC_DEPTH 1024
`define SBSC_SEED_W 2
`define SBSC_WIDE_CFG 1'b1
`define SBSC_SEED_RESET 2'h0
`endif

// ==== rtl/sbsc_pkg.sv ====
// types of the burst sram control block
// assumes sbsc_defs.svh is on the include path
`include "sbsc_defs.svh"
package sbsc_pkg;
    typedef enum logic [1:0] {
        SBSC_IDLE,
        SBSC_READ,
        SBSC_WRITE
    } sbsc_cycle_t;
    typedef logic [`SBSC_SEED_W-1:0] sbsc_seed_t;
endpackage

// ==== rtl/sbsc_mem.sv ====
// byte-lane memory array with registered read data
// assumes synchronous write, one port
`timescale 1ns/1ps
`include "sbsc_defs.svh"
module sbsc_mem (
    input wire logic clk_sys, // clock
    input wire logic clk_en, // freezes all state when low
    input wire logic [`SBSC_ADDR_W-1:0] addr, // word address
    input wire logic [`SBSC_LANES-1:0] lane_we, // per-lane write strobe
    input wire logic [`SBSC_DATA_W-1:0] wdata, // write data
    output logic [`SBSC_DATA_W-1:0] rdata_q // registered read data
);
    logic [`SBSC_DATA_W-1:0] mem_q [0:`SBSC_DEPTH-1];

    genvar g;
    generate
        for (g = 0; g < `SBSC_LANES; g++)
        begin : g_lane
            always_ff @(posedge clk_sys)
            begin
                if (clk_en && lane_we[g])
                begin
                    mem_q[addr][g*`SBSC_LANE_W +: `SBSC_LANE_W] <=
                        wdata[g*`SBSC_LANE_W +: `SBSC_LANE_W];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (clk_en)
        begin
            rdata_q <= mem_q[addr];
        end
    end
endmodule

// ==== rtl/sbsc_top.sv ====
// synchronous burst sram control: decode, burst counter, output stage
// assumes host inputs are synchronous to clk_sys; data pins split in/out/oe
// Function
// RULE1 - low address bits seed burst counter
// RULE2 - linear adds one, interleaved xors step
// RULE3 - counter returns to seed on fifth clock
// RULE4 - counter steps only when step input low
// RULE5 - either load strobe loads address, starts burst; code honours the processor strobe only with the first select low
// RULE6 - selected only with all chip selects true
// RULE7 - output enable gates drivers asynchronously; code samples it on the rising edge instead
// RULE8 - flowthrough bypasses output register, else pipelined
// RULE9 - sleep request enters standby, keeps contents
// RULE10 - open pins default pipelined and active
// RULE11 - global write writes all lanes
// RULE12 - gate high or no lanes means read
// RULE13 - each low lane enable writes lane
// RULE14 - one enable per byte lane with parity
// RULE15 - reads drive all lanes
// RULE16 - writes keep all lanes high impedance
// RULE17 - upper lanes only in wide configuration
// RULE18 - controls sampled on rising edge
// RULE19 - deselect turns outputs off one stage early
// RULE20 - host keeps mode pins stable
`timescale 1ns/1ps
`include "sbsc_defs.svh"
module sbsc_top (
    input wire logic clk_sys, // clock, 100 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic [`SBSC_ADDR_W-1:0] addr_in, // external address
    input wire logic chip_select_low_first, // active low select
    input wire logic chip_select_low_second, // active low select
    input wire logic chip_select_high, // active high select
    input wire logic cpu_load_strobe_n, // processor load strobe
    input wire logic ctrl_load_strobe_n, // controller load strobe
    input wire logic burst_step_n, // burst advance, active low
    input wire logic all_byte_write_n, // global write, active low
    input wire logic byte_write_gate_n, // byte write gate, active low
    input wire logic lane0_write_n, // lane 0 write enable
    input wire logic lane1_write_n, // lane 1 write enable
    input wire logic lane2_write_n, // lane 2 write enable
    input wire logic lane3_write_n, // lane 3 write enable
    input wire logic out_enable_n, // output enable, active low, sampled on rising edge
    input wire logic linear_order_sel_n, // low linear, high interleaved
    input wire logic flowthrough_sel_n, // low flowthrough, tie high if open
    input wire logic sleep_request, // high standby, tie low if open
    input wire logic [`SBSC_DATA_W-1:0] data_in, // data pins, input side
    output logic [`SBSC_DATA_W-1:0] data_out_q, // data pins, output side
    output logic [`SBSC_LANES-1:0] data_oe_n_q, // per-lane enable, low drives
    output logic [`SBSC_SEED_W-1:0] burst_addr_q, // current burst low bits
    output logic standby_q // device in standby
);
    logic selected;
    logic load;
    logic cont;
    logic [`SBSC_LANES-1:0] lane_req_n;
    logic [`SBSC_LANES-1:0] lane_wr;
    logic [`SBSC_LANES-1:0] lane_we;
    logic [`SBSC_ADDR_W-1:0] base_q;
    logic [`SBSC_SEED_W-1:0] seed_q;
    logic [`SBSC_SEED_W-1:0] seed_d;
    logic [`SBSC_SEED_W-1:0] step_q;
    logic [`SBSC_SEED_W-1:0] step_d;
    logic [`SBSC_SEED_W-1:0] cur_low;
    logic [`SBSC_ADDR_W-1:0] mem_addr;
    logic [`SBSC_DATA_W-1:0] rdata;
    logic [`SBSC_DATA_W-1:0] pipe_q;
    logic active;
    logic run;
    logic rd_now;
    logic wr_now;
    logic rd_s1_q;
    logic rd_s2_q;
    logic burst_wr_q;
    sbsc_pkg::sbsc_cycle_t cyc_q;
    sbsc_pkg::sbsc_cycle_t cyc_d;

    // counter value from seed and step count
    function automatic logic [`SBSC_SEED_W-1:0] burst_seq(
        input logic [`SBSC_SEED_W-1:0] seed,
        input logic [`SBSC_SEED_W-1:0] step,
        input logic interleave
    );
        if (interleave)
        begin
            burst_seq = seed ^ step; // RULE2
        end
        else
        begin
            burst_seq = seed + step; // RULE2
        end
    endfunction

    // lane map: narrow builds drop the upper two lanes
    function automatic logic [`SBSC_LANES-1:0] lane_map(
        input logic [`SBSC_LANES-1:0] req_n
    );
        lane_map = ~req_n;
        if (!`SBSC_WIDE_CFG)
        begin
            lane_map[3:2] = 2'h0; // RULE17
        end
    endfunction

    assign active = !sleep_request; // RULE9 RULE10
    assign run = clk_en && active;
    assign selected = !chip_select_low_first && !chip_select_low_second
        && chip_select_high; // RULE6
    // processor strobe only honoured when first select is low
    assign load = (!cpu_load_strobe_n && !chip_select_low_first)
        || !ctrl_load_strobe_n; // RULE5
    assign cont = cpu_load_strobe_n && ctrl_load_strobe_n;
    assign lane_req_n = {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n}; // RULE14

    always_comb
    begin
        if (!all_byte_write_n)
        begin
            lane_wr = {`SBSC_LANES{1'b1}}; // RULE11
        end
        else if (byte_write_gate_n)
        begin
            lane_wr = '0; // RULE12
        end
        else
        begin
            lane_wr = lane_map(lane_req_n); // RULE13
        end
    end

    // cpu strobe starts a read regardless of write pins
    always_comb
    begin
        cyc_d = sbsc_pkg::SBSC_IDLE;
        if (load)
        begin
            if (!selected)
            begin
                cyc_d = sbsc_pkg::SBSC_IDLE;
            end
            else if (!cpu_load_strobe_n || lane_wr == '0)
            begin
                cyc_d = sbsc_pkg::SBSC_READ; // RULE12
            end
            else
            begin
                cyc_d = sbsc_pkg::SBSC_WRITE;
            end
        end
        else
        begin
            // a running burst continues; write pins pick its direction
            case (cyc_q)
                sbsc_pkg::SBSC_READ,
                sbsc_pkg::SBSC_WRITE:
                begin
                    cyc_d = (lane_wr == '0) ? sbsc_pkg::SBSC_READ : sbsc_pkg::SBSC_WRITE;
                end
                default:
                begin
                    cyc_d = sbsc_pkg::SBSC_IDLE;
                end
            endcase
        end
    end

    always_comb
    begin
        step_d = step_q;
        if (load)
        begin
            step_d = '0; // RULE1
        end
        else if (cont && !burst_step_n)
        begin
            step_d = step_q + 2'h1; // RULE4 RULE3
        end
    end

    // seed the next cycle uses, so the burst output leads with a new load
    always_comb
    begin
        seed_d = seed_q;
        if (load)
        begin
            seed_d = addr_in[`SBSC_SEED_W-1:0]; // RULE1
        end
    end

    // address capture, sampled on rising edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_q <= '0;
            seed_q <= `SBSC_SEED_RESET;
            step_q <= '0;
        end
        else if (run)
        begin
            if (load)
            begin
                base_q <= addr_in; // RULE18
                seed_q <= addr_in[`SBSC_SEED_W-1:0]; // RULE1
            end
            step_q <= step_d; // RULE3
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_q <= sbsc_pkg::SBSC_IDLE;
        end
        else if (run)
        begin
            cyc_q <= cyc_d; // RULE18
        end
    end

    assign cur_low = burst_seq(seed_q, step_q, linear_order_sel_n);
    assign mem_addr = {base_q[`SBSC_ADDR_W-1:`SBSC_SEED_W], cur_low};
    // write data arrives with the captured cycle (late-write style)
    assign wr_now = run && (cyc_q == sbsc_pkg::SBSC_WRITE);
    assign rd_now = run && (cyc_q == sbsc_pkg::SBSC_READ);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            burst_wr_q <= 1'b0;
        end
        else if (run)
        begin
            burst_wr_q <= (cyc_d == sbsc_pkg::SBSC_WRITE);
        end
    end

    // lane strobes follow the cycle's own lane pattern, captured with it
    logic [`SBSC_LANES-1:0] lane_wr_q;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lane_wr_q <= '0;
        end
        else if (run)
        begin
            lane_wr_q <= lane_wr;
        end
    end
    assign lane_we = (wr_now && burst_wr_q) ? lane_wr_q : '0; // RULE13

    sbsc_mem u_mem (
        .clk_sys(clk_sys),
        .clk_en(run),
        .addr(mem_addr),
        .lane_we(lane_we),
        .wdata(data_in),
        .rdata_q(rdata)
    );

    // read valid stages: s1 when array data ready, s2 after output register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_s1_q <= 1'b0;
            rd_s2_q <= 1'b0;
            pipe_q <= '0;
        end
        else if (run)
        begin
            rd_s1_q <= rd_now;
            rd_s2_q <= rd_s1_q && (cyc_q != sbsc_pkg::SBSC_IDLE); // RULE19
            pipe_q <= rdata;
        end
    end

    // outputs are flops; enable tracks the async pin on every clock with clk_en high
    // limitation: true async release cannot come from a flop, so we
    // register and also clear immediately via the async reset path only
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_out_q <= '0;
            data_oe_n_q <= {`SBSC_LANES{1'b1}};
        end
        else if (clk_en)
        begin
            if (!flowthrough_sel_n)
            begin
                data_out_q <= rdata; // RULE8
            end
            else
            begin
                data_out_q <= pipe_q; // RULE8 RULE10
            end
            // a write load turns drivers off at once, not a cycle later
            if (out_enable_n || !active || wr_now || (run && cyc_d == sbsc_pkg::SBSC_WRITE))
            begin
                data_oe_n_q <= {`SBSC_LANES{1'b1}}; // RULE7 RULE16
            end
            else if (!flowthrough_sel_n ? rd_s1_q : rd_s2_q)
            begin
                data_oe_n_q <= '0; // RULE15
            end
            else
            begin
                data_oe_n_q <= {`SBSC_LANES{1'b1}}; // RULE19
            end
        end
    end

    // burst output mirrors the low address the next cycle will use
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            burst_addr_q <= `SBSC_SEED_RESET;
        end
        else if (run)
        begin
            burst_addr_q <= burst_seq(seed_d, step_d, linear_order_sel_n); // RULE1 RULE2
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            standby_q <= 1'b0;
        end
        else if (clk_en)
        begin
            standby_q <= sleep_request; // RULE9
        end
    end
endmodule

// ==== dv/sbsc_props.sv ====
// port assertions of the burst sram control
// assumes binding onto sbsc_top, one clock domain
`timescale 1ns/1ps
`include "sbsc_defs.svh"
module sbsc_props (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic clk_en, // enable
    input wire logic [`SBSC_ADDR_W-1:0] addr_in, // address
    input wire logic chip_select_low_first, // select
    input wire logic chip_select_low_second, // select
    input wire logic chip_select_high, // select
    input wire logic cpu_load_strobe_n, // load
    input wire logic ctrl_load_strobe_n, // load
    input wire logic burst_step_n, // step
    input wire logic all_byte_write_n, // write
    input wire logic out_enable_n, // enable
    input wire logic linear_order_sel_n, // order
    input wire logic sleep_request, // sleep
    input wire logic [`SBSC_LANES-1:0] data_oe_n_q, // drivers
    input wire logic [`SBSC_SEED_W-1:0] burst_addr_q, // burst
    input wire logic standby_q // standby
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire run = clk_en && !sleep_request;
    wire sel = !chip_select_low_first && !chip_select_low_second && chip_select_high;
    wire keep = cpu_load_strobe_n && ctrl_load_strobe_n;
    sequence load_s;
        run && sel && !keep;
    endsequence
    sequence wr_s;
        load_s ##0 !all_byte_write_n;
    endsequence
    seed_load_a: assert property (load_s |=> burst_addr_q == $past(addr_in[1:0]))
        else $error("burst seed not loaded");
    linear_step_a: assert property (run && keep && !burst_step_n && !linear_order_sel_n
        |=> burst_addr_q == $past(burst_addr_q) + 2'h1) else $error("linear step wrong");
    burst_hold_a: assert property (run && keep && burst_step_n |=> $stable(burst_addr_q))
        else $error("burst address moved");
    standby_track_a: assert property (clk_en |=> standby_q == $past(sleep_request))
        else $error("standby wrong");
    sleep_off_a: assert property (standby_q [*2] |-> data_oe_n_q == 4'hf)
        else $error("drivers on in standby");
    oe_gate_a: assert property (clk_en && out_enable_n |=> data_oe_n_q == 4'hf)
        else $error("drivers on with enable high");
    lanes_together_a: assert property (data_oe_n_q == 4'h0 || data_oe_n_q == 4'hf)
        else $error("lanes driven apart");
    deselect_off_a: assert property (run && !sel && !ctrl_load_strobe_n
        |-> ##[1:3] data_oe_n_q == 4'hf) else $error("drivers on after deselect");
    write_hiz_a: assert property (wr_s ##1 data_oe_n_q == 4'hf |=> data_oe_n_q == 4'hf)
        else $error("drivers on in write");
endmodule
bind sbsc_top sbsc_props sbsc_props_inst (.*);

// ==== dv/sbsc_host.sv ====
// host side of the data pins, resolving the shared wire per lane
// assumes device enables are low while it drives
`timescale 1ns/1ps
`include "sbsc_defs.svh"
module sbsc_host (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic host_oe, // host drives
    input wire logic [`SBSC_DATA_W-1:0] host_data, // host data
    input wire logic [`SBSC_DATA_W-1:0] data_out_q, // device data
    input wire logic [`SBSC_LANES-1:0] data_oe_n_q, // device enables
    output logic [`SBSC_DATA_W-1:0] data_in // wire level
);
    logic [`SBSC_DATA_W-1:0] last_q;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            last_q <= '0;
        else
            last_q <= data_in;
    end
    // undriven lanes flip every cycle so stale data never matches
    always_comb
    begin
        for (int i = 0; i < `SBSC_LANES; i++)
        begin
            if (!data_oe_n_q[i])
                data_in[i*9 +: 9] = data_out_q[i*9 +: 9];
            else
                data_in[i*9 +: 9] = host_oe ? host_data[i*9 +: 9] : ~last_q[i*9 +: 9];
        end
    end
endmodule

// ==== dv/tb_sbsc_top.sv ====
// testbench of the burst sram control
// assumes sbsc_top, sbsc_host and the bound checker
`timescale 1ns/1ps
`include "sbsc_defs.svh"
module tb_sbsc_top;
    logic clk_sys, rst_n, clk_en, chip_select_low_first, chip_select_low_second;
    logic chip_select_high, cpu_load_strobe_n, ctrl_load_strobe_n, burst_step_n;
    logic all_byte_write_n, byte_write_gate_n, lane0_write_n, lane1_write_n;
    logic lane2_write_n, lane3_write_n, out_enable_n, linear_order_sel_n;
    logic flowthrough_sel_n, sleep_request, host_oe, standby_q, use_cpu;
    logic [`SBSC_ADDR_W-1:0] addr_in;
    logic [`SBSC_DATA_W-1:0] data_in, data_out_q, host_data, mem;
    logic [`SBSC_LANES-1:0] data_oe_n_q;
    logic [1:0] burst_addr_q;
    int fails = 0;
    int compares = 0;
    localparam logic [35:0] pat_a = 36'h1_2345_6789;
    localparam logic [35:0] pat_b = 36'hf_edcb_a987;
    sbsc_top sbsc_top_inst (.*);
    sbsc_host sbsc_host_inst (.*);
    always #5 clk_sys = ~clk_sys;
    task automatic stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic op(input logic [9:0] a, input logic s, gw, bg, input logic [3:0] ln);
        @(negedge clk_sys);
        addr_in = a;
        chip_select_high = s;
        ctrl_load_strobe_n = use_cpu;
        cpu_load_strobe_n = !use_cpu;
        {all_byte_write_n, byte_write_gate_n} = {gw, bg};
        {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n} = ln;
        @(negedge clk_sys);
        {chip_select_high, ctrl_load_strobe_n, all_byte_write_n, byte_write_gate_n} = 4'hf;
        cpu_load_strobe_n = 1'b1;
    endtask
    task automatic wr(input logic gw, bg, input logic [3:0] ln, input logic [35:0] d);
        op(10'h010, 1'b1, gw, bg, ln);
        host_oe = 1'b1;
        host_data = d;
        @(negedge clk_sys);
        host_oe = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic rd(input logic [35:0] exp, input logic [3:0] oe);
        op(10'h010, 1'b1, 1'b1, 1'b1, 4'hf);
        repeat (flowthrough_sel_n ? 4 : 3) @(posedge clk_sys);
        #1;
        check("read enables", data_oe_n_q, oe);
        if (oe == 4'h0)
            check("read data", data_out_q, exp);
        op(10'h010, 1'b0, 1'b1, 1'b1, 4'hf);
        repeat (4) @(negedge clk_sys);
    endtask
    // whole run is about 150 cycles
    initial
    begin
        #20000;
        fails++;
        stop_test();
    end
    initial
    begin
        {clk_sys, rst_n, addr_in, chip_select_low_first, chip_select_low_second} = '0;
        {out_enable_n, linear_order_sel_n, sleep_request, host_oe, host_data, use_cpu} = '0;
        {clk_en, chip_select_high, cpu_load_strobe_n, ctrl_load_strobe_n, burst_step_n} = '1;
        {all_byte_write_n, byte_write_gate_n, flowthrough_sel_n} = '1;
        {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n} = '1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        check("reset data", data_out_q, '0);
        check("reset flags", {data_oe_n_q, burst_addr_q, standby_q}, 7'h78);
        wr(1'b0, 1'b0, 4'he, pat_a);
        rd(pat_a, 4'h0);
        wr(1'b1, 1'b1, 4'h0, pat_b);
        wr(1'b1, 1'b0, 4'hf, pat_b);
        rd(pat_a, 4'h0);
        mem = pat_a;
        for (int k = 0; k < 2; k++)
        begin
            wr(1'b1, 1'b0, k ? 4'h6 : 4'hd, pat_b);
            for (int i = 0; i < 4; i++)
                if ((((k ? 4'h6 : 4'hd) >> i) & 4'h1) == 4'h0)
                    mem[i*9 +: 9] = pat_b[i*9 +: 9];
            rd(mem, 4'h0);
        end
        flowthrough_sel_n = 1'b0;
        rd(mem, 4'h0);
        flowthrough_sel_n = 1'b1;
        out_enable_n = 1'b1;
        rd(mem, 4'hf);
        out_enable_n = 1'b0;
        op(10'h010, 1'b1, 1'b1, 1'b1, 4'hf);
        repeat (3) @(negedge clk_sys);
        check("reading", data_oe_n_q, 4'h0);
        chip_select_low_second = 1'b1;
        op(10'h010, 1'b1, 1'b1, 1'b1, 4'hf);
        repeat (3) @(posedge clk_sys);
        #1;
        check("deselected", data_oe_n_q, 4'hf);
        @(negedge clk_sys);
        chip_select_low_second = 1'b0;
        sleep_request = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("standby", {standby_q, data_oe_n_q}, 5'h1f);
        sleep_request = 1'b0;
        rd(mem, 4'h0);
        for (int m = 0; m < 2; m++)
        begin
            logic [1:0] s;
            logic [1:0] e;
            s = 2'h3 - m[1:0];
            linear_order_sel_n = m[0];
            use_cpu = m[0];
            op({8'h05, s}, 1'b1, 1'b1, 1'b1, 4'hf);
            burst_step_n = 1'b0;
            for (int i = 0; i < 5; i++)
            begin
                e = m ? s ^ i[1:0] : s + i[1:0];
                check("burst address", burst_addr_q, e);
                @(negedge clk_sys);
            end
            burst_step_n = 1'b1;
            repeat (2) @(negedge clk_sys);
            e = m ? s ^ 2'h1 : s + 2'h1;
            check("burst hold", burst_addr_q, e);
            clk_en = 1'b0;
            burst_step_n = 1'b0;
            repeat (2) @(negedge clk_sys);
            check("frozen burst", burst_addr_q, e);
            {clk_en, burst_step_n} = 2'h3;
            op(10'h010, 1'b0, 1'b1, 1'b1, 4'hf);
            repeat (4) @(negedge clk_sys);
        end
        stop_test();
    end
endmodule
